// ### hdl/sdcb_ctl.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sdcb_params.svh"
module sdcb_ctl (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link to the device
	sdcb_if.ctl lnk
);
	// ----------------------------------------------------------
	// registers
	// ----------------------------------------------------------
	localparam logic [3:0] T_RCD = 4'(`SDCB_CYC_MIN(`SDCB_T_ACT_ACC_NS));
	localparam logic [3:0] T_RC = 4'(`SDCB_CYC_MIN(`SDCB_T_SAME_ACT_NS));
	localparam logic [3:0] T_RRD = 4'(`SDCB_CYC_MIN(`SDCB_T_CROSS_ACT_NS));
	localparam logic [3:0] T_RAS = 4'(`SDCB_CYC_MIN(`SDCB_T_RAS_MIN_NS));
	logic [31:0] addr_r;
	logic [3:0] mask_r;
	logic [31:0] rdata_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pend_r;
	sdcb_pkg::sdcb_cmd_e cmd_r;
	logic [3:0] acc_cnt_r [4];
	logic [3:0] rc_cnt_r [4];
	logic [3:0] ras_cnt_r [4];
	logic [3:0] rrd_cnt_r;
	logic [3:0] lead_r;
	logic [3:0] mask_o_r;
	logic [1:0] bs_r;
	logic [11:0] a_r;
	logic ras_n_r, cas_n_r, we_n_r, cs_n_r;
	logic pslverr_r;
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire [1:0] cb = addr_r[13:12];
	wire hit_cmd = (paddr == `SDCB_REG_CMD);
	wire hit_addr = (paddr == `SDCB_REG_ADDR);
	wire hit_stat = (paddr == `SDCB_REG_STAT);
	wire hit_rd = (paddr == `SDCB_REG_RDATA);
	wire hit_mask = (paddr == `SDCB_REG_MASK);
	wire hit_any = hit_cmd | hit_addr | hit_stat | hit_rd | hit_mask;
	// ----------------------------------------------------------
	// timing gate before issue
	// ----------------------------------------------------------
	wire is_acc = (cmd_r == sdcb_pkg::sdcb_read)
		| (cmd_r == sdcb_pkg::sdcb_write);
	wire is_open = (cmd_r == sdcb_pkg::sdcb_open);
	wire is_cls = (cmd_r == sdcb_pkg::sdcb_close)
		| (cmd_r == sdcb_pkg::sdcb_close_all);
	// close-all must wait for every bank's row active time
	wire ras_ok = (cmd_r == sdcb_pkg::sdcb_close_all)
		? (ras_cnt_r[0] == 4'h0 && ras_cnt_r[1] == 4'h0
		&& ras_cnt_r[2] == 4'h0 && ras_cnt_r[3] == 4'h0)
		: (ras_cnt_r[cb] == 4'h0);
	wire t_ok = (!is_acc || acc_cnt_r[cb] == 4'h0)
		&& (!is_open || (rc_cnt_r[cb] == 4'h0 && rrd_cnt_r == 4'h0))
		&& (!is_cls || ras_ok)
		// mask leads a write
		&& (cmd_r != sdcb_pkg::sdcb_write || lead_r == 4'h0);
	wire issue = pend_r & t_ok;
	wire [2:0] code = (cmd_r == sdcb_pkg::sdcb_open) ? 3'b011 :
		is_cls ? 3'b010 :
		(cmd_r == sdcb_pkg::sdcb_read) ? 3'b101 :
		(cmd_r == sdcb_pkg::sdcb_write) ? 3'b100 :
		(cmd_r == sdcb_pkg::sdcb_mode_set) ? 3'b000 :
		(cmd_r == sdcb_pkg::sdcb_refresh) ? 3'b001 :
		(cmd_r == sdcb_pkg::sdcb_stop) ? 3'b110 : 3'b111;
	wire [11:0] a_out = (cmd_r == sdcb_pkg::sdcb_close_all)
		? (addr_r[11:0] | 12'h400) : addr_r[11:0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_r <= 32'h0;
			mask_r <= 4'h0;
			pend_r <= 1'b0;
			cmd_r <= sdcb_pkg::sdcb_nop;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
			rdata_r <= 32'h0;
			lead_r <= 4'h0;
		end else begin
			pready_r <= psel & ~penable;
			pslverr_r <= psel & ~penable & ~hit_any;
			if (wr & pready_r & hit_addr) addr_r <= pwdata;
			if (wr & pready_r & hit_mask) mask_r <= pwdata[3:0];
			if (wr & pready_r & hit_cmd & ~pend_r) begin
				pend_r <= 1'b1;
				cmd_r <= sdcb_pkg::sdcb_cmd_e'(pwdata[3:0]);
				lead_r <= (pwdata[3:0] == 4'(sdcb_pkg::sdcb_write))
					? 4'(`SDCB_MASK_LEAD) : 4'h0;
			end else if (issue) begin
				pend_r <= 1'b0;
			end else if (lead_r != 4'h0) begin
				lead_r <= lead_r - 4'h1;
			end
			if (lnk.dq_dev_oe != 4'h0) rdata_r <= lnk.dq_dev;
			prdata_r <= hit_stat ? {31'h0, pend_r} :
				hit_rd ? rdata_r : hit_addr ? addr_r :
				hit_mask ? {28'h0, mask_r} : 32'h0;
		end
	end
	generate
		for (genvar g = 0; g < 4; g++) begin : gc
			wire me = (cb == 2'(g));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					acc_cnt_r[g] <= 4'h0;
					rc_cnt_r[g] <= 4'h0;
					ras_cnt_r[g] <= 4'h0;
				end else if (issue & is_open & me) begin
					acc_cnt_r[g] <= T_RCD - 4'h1;
					rc_cnt_r[g] <= T_RC - 4'h1;
					ras_cnt_r[g] <= T_RAS - 4'h1;
				end else begin
					if (acc_cnt_r[g] != 4'h0) acc_cnt_r[g] <= acc_cnt_r[g] - 4'h1;
					if (rc_cnt_r[g] != 4'h0) rc_cnt_r[g] <= rc_cnt_r[g] - 4'h1;
					if (ras_cnt_r[g] != 4'h0) ras_cnt_r[g] <= ras_cnt_r[g] - 4'h1;
				end
			end
		end
	endgenerate
	// ----------------------------------------------------------
	// pins
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rrd_cnt_r <= 4'h0;
			{cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'hF;
			bs_r <= 2'h0;
			a_r <= 12'h000;
			mask_o_r <= 4'h0;
		end else begin
			rrd_cnt_r <= (issue & is_open) ? T_RRD - 4'h1 :
				(rrd_cnt_r != 4'h0) ? rrd_cnt_r - 4'h1 : 4'h0;
			cs_n_r <= ~issue;
			{ras_n_r, cas_n_r, we_n_r} <= issue ? code : 3'b111;
			bs_r <= cb;
			a_r <= a_out;
			mask_o_r <= (pend_r & cmd_r == sdcb_pkg::sdcb_write) ? 4'hF : mask_r;
		end
	end
	assign lnk.cke = 1'b1;
	assign lnk.cs_n = cs_n_r;
	assign lnk.ras_n = ras_n_r;
	assign lnk.cas_n = cas_n_r;
	assign lnk.we_n = we_n_r;
	assign lnk.bank_select_pins = bs_r;
	assign lnk.addr = a_r;
	assign lnk.byte_lane_mask = mask_o_r;
	assign lnk.dq_ctl = 32'h0;
	assign lnk.dq_ctl_oe = 1'b0;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule
`default_nettype wire

// ### hdl/sdcb_params.svh
`ifndef SDCB_PARAMS_SVH
`define SDCB_PARAMS_SVH
// timing of the far end, in ns, converted to clock cycles at 50 ns
`define SDCB_CLK_NS 50
`define SDCB_T_ACT_ACC_NS 20
`define SDCB_T_SAME_ACT_NS 70
`define SDCB_T_CROSS_ACT_NS 14
`define SDCB_T_RAS_MIN_NS 49
`define SDCB_CYC_UP(t) (((t) + `SDCB_CLK_NS - 1) / `SDCB_CLK_NS)
`define SDCB_CYC_MIN(t) ((`SDCB_CYC_UP(t) < 1) ? 1 : `SDCB_CYC_UP(t))
// mode register fields
`define SDCB_MODE_BL_LSB 0
`define SDCB_MODE_BL_MSB 2
`define SDCB_MODE_CL_LSB 4
`define SDCB_MODE_CL_MSB 6
`define SDCB_BL_FULL 3'h7
`define SDCB_CL_LONG 3'h3
`define SDCB_ADDR_FLAG 10
`define SDCB_MODE_RESET 14'h0020
// controller registers on apb
`define SDCB_REG_CMD 12'h000
`define SDCB_REG_ADDR 12'h004
`define SDCB_REG_STAT 12'h008
`define SDCB_REG_RDATA 12'h00C
`define SDCB_REG_MASK 12'h010
`define SDCB_MASK_LEAD 2
`endif

// ### hdl/sdcb_pkg.sv
package sdcb_pkg;
	typedef enum logic [3:0] {
		sdcb_nop, sdcb_open, sdcb_close, sdcb_close_all, sdcb_read,
		sdcb_write, sdcb_mode_set, sdcb_refresh, sdcb_stop
	} sdcb_cmd_e;
endpackage

// ### hdl/sdcb_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sdcb_if (input wire logic pclk);
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] bank_select_pins;
	logic [11:0] addr;
	logic [3:0] byte_lane_mask;
	logic [31:0] dq_ctl;
	logic dq_ctl_oe;
	logic [31:0] dq_dev;
	logic [3:0] dq_dev_oe;
	modport dev (input pclk, cke, cs_n, ras_n, cas_n, we_n,
		bank_select_pins, addr, byte_lane_mask, dq_ctl, dq_ctl_oe,
		output dq_dev, dq_dev_oe);
	modport ctl (input pclk, dq_dev, dq_dev_oe,
		output cke, cs_n, ras_n, cas_n, we_n, bank_select_pins, addr,
		byte_lane_mask, dq_ctl, dq_ctl_oe);
endinterface
`default_nettype wire

// ### hdl/sdcb_dev.sv
// Overview of operation
// - row open activates chosen bank, latches row
// - controller waits activate-to-access delay
// - reopen same bank only after close, spaced
// - space row opens across banks
// - bank close idles only selected bank
// - controller honours minimum row active time before close
// - close all idles every bank
// - read takes column, auto-close flag
// - first read word after latency, then each clock
// - data pins released when burst ends
// - full page bursts wrap until stopped
// - byte mask blocks read data two clocks later
// - new access or close cuts read short
// - controller masks two clocks before write
// - controller leaves one idle bus cycle
// - controller masks early for second write clock
// - decode uses current and prior clock gate
// - gate low during burst freezes burst
// - chip select high means deselect
// - each mask bit covers one byte lane
// - mode set loads pins when all idle
`timescale 1ns/1ns
`default_nettype none
`include "sdcb_params.svh"
module sdcb_dev #(
	parameter int NBANK = 4,
	parameter int COLW = 8
) (
	// link to the controller
	sdcb_if.dev lnk,
	// reset
	input wire logic presetn,
	// user side: state view
	output logic [3:0] bank_active,
	output logic [13:0] mode_reg,
	output logic [47:0] open_rows,
	output logic suspended
);
	// ----------------------------------------------------------
	// command decode
	// ----------------------------------------------------------
	logic prior_clock_gate_sample_r;
	logic [3:0] act_r;
	logic [11:0] row_r [NBANK];
	logic [13:0] mode_r;
	logic bursting_r;
	logic [COLW-1:0] col_r;
	logic [1:0] rbank_r;
	logic auto_r;
	logic [8:0] left_r;
	logic [1:0] pipe_v_r;
	logic [3:0] msk1_r;
	logic [31:0] dq_r;
	logic [3:0] oe_r;
	logic susp_r;
	// prior sample resets low: the first edge after reset decodes nothing
	// ordinary commands need the prior sample high
	wire run = prior_clock_gate_sample_r & lnk.cke;
	// deselect masks every command
	wire sel = run & ~lnk.cs_n;
	wire [2:0] code = {lnk.ras_n, lnk.cas_n, lnk.we_n};
	wire [1:0] bs = lnk.bank_select_pins;
	wire flag = lnk.addr[`SDCB_ADDR_FLAG];
	// a command whose bank precondition fails is dropped
	wire is_open = sel & (code == 3'b011) & ~act_r[bs];
	wire is_close = sel & (code == 3'b010) & ~flag;
	wire is_close_all = sel & (code == 3'b010) & flag;
	wire is_read = sel & (code == 3'b101) & act_r[bs];
	wire is_write = sel & (code == 3'b100) & act_r[bs];
	wire is_mode = sel & (code == 3'b000) & (act_r == 4'h0);
	wire is_stop = sel & (code == 3'b110);
	wire [2:0] bl = mode_r[`SDCB_MODE_BL_MSB:`SDCB_MODE_BL_LSB];
	wire [2:0] cl = mode_r[`SDCB_MODE_CL_MSB:`SDCB_MODE_CL_LSB];
	wire full = (bl == `SDCB_BL_FULL);
	wire [8:0] blen = full ? 9'h000 : (9'h001 << bl);
	// cut by new access or close of the burst's bank
	wire cut = is_read | is_write | is_stop | is_close_all
		| (is_close & (bs == rbank_r));
	// gate low freezes an active burst
	wire frz = bursting_r & ~lnk.cke;
	wire go_on = bursting_r & ~frz & ~cut;
	// the read edge yields the first word; left_r counts the rest
	wire word_now = go_on & (full | (left_r != 9'h000));
	// a burst ends one edge after its last word, starting auto-close
	wire burst_end = go_on & ~full & (left_r == 9'h000);
	// ----------------------------------------------------------
	// bank state
	// ----------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NBANK; g++) begin : gb
			wire hit = (bs == 2'(g));
			wire auto_done = burst_end & auto_r & (rbank_r == 2'(g));
			always_ff @(posedge lnk.pclk or negedge presetn) begin
				if (!presetn) begin
					act_r[g] <= 1'b0;
					row_r[g] <= 12'h000;
				end else if (is_open & hit) begin
					act_r[g] <= 1'b1;
					row_r[g] <= lnk.addr;
				end else if (is_close_all) begin
					act_r[g] <= 1'b0;
				end else if ((is_close & hit) | auto_done) begin
					act_r[g] <= 1'b0;
				end
			end
			assign open_rows[g*12 +: 12] = row_r[g];
		end
	endgenerate
	// ----------------------------------------------------------
	// clock gate history
	// ----------------------------------------------------------
	always_ff @(posedge lnk.pclk or negedge presetn) begin
		if (!presetn) begin
			prior_clock_gate_sample_r <= 1'b0;
			susp_r <= 1'b0;
		end else begin
			prior_clock_gate_sample_r <= lnk.cke;
			// suspend lasts while the gate stays low after a frozen burst
			susp_r <= frz | (susp_r & ~lnk.cke);
		end
	end
	// ----------------------------------------------------------
	// mode register
	// ----------------------------------------------------------
	always_ff @(posedge lnk.pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= `SDCB_MODE_RESET;
		end else if (is_mode) begin
			mode_r <= {bs, lnk.addr};
		end
	end
	// ----------------------------------------------------------
	// burst engine
	// ----------------------------------------------------------
	always_ff @(posedge lnk.pclk or negedge presetn) begin
		if (!presetn) begin
			bursting_r <= 1'b0;
			col_r <= '0;
			rbank_r <= 2'h0;
			auto_r <= 1'b0;
			left_r <= 9'h000;
		end else if (is_read) begin
			bursting_r <= 1'b1;
			col_r <= lnk.addr[COLW-1:0] + 1'b1;
			rbank_r <= bs;
			auto_r <= flag;
			left_r <= blen - 9'h001;
		end else if (cut | burst_end) begin
			bursting_r <= 1'b0;
		end else if (word_now) begin
			col_r <= col_r + 1'b1; // wraps to column 0
			left_r <= left_r - 9'h001;
		end
	end
	// ----------------------------------------------------------
	// output pipe for read latency and mask
	// ----------------------------------------------------------
	wire word_in = is_read | word_now;
	wire [COLW-1:0] col_in = is_read ? lnk.addr[COLW-1:0] : col_r;
	wire [1:0] bank_in = is_read ? bs : rbank_r;
	// data word made from bank, row and column; there is no storage
	wire [31:0] word_val = {row_r[bank_in], {(20-COLW){1'b0}}, col_in}
		^ {30'h0, bank_in};
	wire long_cl = (cl == `SDCB_CL_LONG);
	// word due on the pins after this edge
	wire due = long_cl ? pipe_v_r[1] : pipe_v_r[0];
	logic [31:0] pd_r [2];
	always_ff @(posedge lnk.pclk or negedge presetn) begin
		if (!presetn) begin
			pipe_v_r <= 2'h0;
			dq_r <= 32'h0;
			pd_r[0] <= 32'h0;
			pd_r[1] <= 32'h0;
		end else if (!frz) begin
			// latency stages
			pipe_v_r <= {pipe_v_r[0], word_in};
			pd_r[0] <= word_val;
			pd_r[1] <= pd_r[0];
			dq_r <= long_cl ? pd_r[1] : pd_r[0];
		end
	end
	// ----------------------------------------------------------
	// per-lane mask and output enable
	// ----------------------------------------------------------
	genvar l;
	generate
		for (l = 0; l < 4; l++) begin : gl
			always_ff @(posedge lnk.pclk or negedge presetn) begin
				if (!presetn) begin
					msk1_r[l] <= 1'b0;
					oe_r[l] <= 1'b0;
				end else if (!frz) begin
					// mask taken two clocks ahead
					msk1_r[l] <= lnk.byte_lane_mask[l];
					// lane on while word due
					oe_r[l] <= due & ~msk1_r[l];
				end
			end
		end
	endgenerate
	assign lnk.dq_dev = dq_r;
	assign lnk.dq_dev_oe = oe_r;
	assign bank_active = act_r;
	assign mode_reg = mode_r;
	assign suspended = susp_r;
endmodule
`default_nettype wire

// ### dv/sdcb_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sdcb_sva (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] bank_select_pins,
	input wire logic [11:0] addr,
	// data lanes
	input wire logic [3:0] byte_lane_mask,
	input wire logic dq_ctl_oe,
	input wire logic [3:0] dq_dev_oe
);
	logic [3:0] open_r;
	logic [3:0] open_nxt;
	wire logic go = cke && !cs_n;
	wire logic act = go && !ras_n && cas_n && we_n;
	wire logic pre = go && !ras_n && cas_n && !we_n;
	wire logic rd = go && ras_n && !cas_n && we_n;
	wire logic wr = go && ras_n && !cas_n && !we_n;
	wire logic mrs = go && !ras_n && !cas_n && !we_n;
	wire logic [3:0] sel = 4'h1 << bank_select_pins;
	wire logic [3:0] shut = addr[10] ? 4'h0 : (open_r & ~sel);
	// a read with auto-close gives its bank up
	assign open_nxt = act ? (open_r | sel) : pre ? shut
		: (rd && addr[10]) ? (open_r & ~sel) : open_r;
	// -------------------------------------------
	// bank state seen on the pins
	// -------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_r <= 4'h0;
		end else begin
			open_r <= open_nxt;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reopen_idle_a: assert property (
		act |-> (open_r & sel) == 4'h0) else $error("open of open bank");
	open_space_a: assert property (
		act |=> !(act && bank_select_pins == $past(bank_select_pins)))
		else $error("same bank opened too soon");
	access_open_a: assert property (
		(rd || wr) |-> open_r[bank_select_pins]) else $error("idle access");
	mode_idle_a: assert property (
		mrs |-> open_r == 4'h0) else $error("mode set with bank open");
	write_mask_a: assert property (
		wr |-> $past(byte_lane_mask) == 4'hF
		&& $past(byte_lane_mask, 2) == 4'hF) else $error("write unmasked");
	bus_gap_a: assert property (
		dq_ctl_oe |-> dq_dev_oe == 4'h0 && $past(dq_dev_oe) == 4'h0)
		else $error("no idle bus cycle");
	read_data_a: assert property (
		(rd && (byte_lane_mask == 4'h0)) ##1 (byte_lane_mask == 4'h0)
		|-> ##[1:2] (dq_dev_oe == 4'hF))
		else $error("read data missing");
	for (genvar i = 0; i < 4; i++) begin : lane
		mask_block_a: assert property (
			byte_lane_mask[i] |-> ##2 !dq_dev_oe[i])
			else $error("masked lane driven");
	end
	cover property (rd);
	cover property (wr);
	cover property (pre && addr[10]);
	cover property (rd && addr[10]);
endmodule
`default_nettype wire

// ### dv/test_sdram_command_bank_logic.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdcb_params.svh"
module test_sdram_command_bank_logic;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] bank_active;
	logic [13:0] mode_reg;
	logic [47:0] open_rows;
	logic suspended;
	logic [31:0] r;
	logic e;
	int mismatches = 0;
	int num_checks = 0;
	int seed = 32'h1848FBF8;
	int act[4] = '{0, 0, 0, 0};
	int row[4];
	int cl;
	int b;
	int b2;
	int lat = -1;
	int since = -1;
	int hi = 0;
	always #25 pclk = ~pclk;
	sdcb_if lnk (.pclk(pclk));
	sdcb_ctl sdcb_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.ctl));
	sdcb_dev sdcb_dev_i (.lnk(lnk.dev), .presetn(presetn),
		.bank_active(bank_active), .mode_reg(mode_reg),
		.open_rows(open_rows), .suspended(suspended));
	sdcb_sva sdcb_sva_i (.pclk(pclk), .presetn(presetn), .cke(lnk.cke),
		.cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
		.we_n(lnk.we_n), .bank_select_pins(lnk.bank_select_pins),
		.addr(lnk.addr), .byte_lane_mask(lnk.byte_lane_mask),
		.dq_ctl_oe(lnk.dq_ctl_oe), .dq_dev_oe(lnk.dq_dev_oe));
	// -------------------------------------------
	// read monitor: latency and word count
	// -------------------------------------------
	// sampled at the rising edge, before that edge's updates
	always @(posedge pclk) begin
		if (since >= 0) begin
			since++;
		end
		if (lnk.dq_dev_oe != 4'h0) begin
			hi++;
			if (since > 0) begin
				lat = since;
			end
			since = -1;
		end
		if (!lnk.cs_n && lnk.ras_n && !lnk.cas_n && lnk.we_n) begin
			since = 0;
			hi = 0;
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			end_sim();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task cmd(input sdcb_pkg::sdcb_cmd_e op, input int bk, input int a);
		int n;
		apb(1'b1, `SDCB_REG_ADDR, {18'h0, bk[1:0], a[11:0]});
		apb(1'b1, `SDCB_REG_CMD, {28'h0, op});
		n = 0;
		do begin
			apb(1'b0, `SDCB_REG_STAT, 32'h0);
			n++;
		end while (r[0] !== 1'b0 && n < 50);
		if (r[0] !== 1'b0) begin
			mismatches++;
			end_sim();
		end
		repeat (8) @(posedge pclk);
	endtask
	task cmp;
		logic [3:0] ea;
		for (int i = 0; i < 4; i++) begin
			ea[i] = (act[i] != 0);
			if (act[i] != 0) begin
				chk("open_rows", 48'(row[i]), {36'h0, open_rows[i*12 +: 12]});
			end
		end
		chk("bank_active", {44'h0, ea}, {44'h0, bank_active});
	endtask
	task rd(input int bk, input int a);
		lat = -1;
		cmd(sdcb_pkg::sdcb_read, bk, a);
	endtask
	// -------------------------------------------
	// main sequence
	// -------------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		cmp();
		chk("mode_reg", 48'(`SDCB_MODE_RESET), {34'h0, mode_reg});
		apb(1'b0, 12'hFFC, 32'h0);
		chk("pslverr", 48'h1, {47'h0, e});
		for (int c = 2; c <= 3; c++) begin
			cl = c;
			cmd(sdcb_pkg::sdcb_mode_set, 0, c << 4);
			chk("mode_reg", 48'(c << 4), {34'h0, mode_reg});
			for (int k = 0; k < 4; k++) begin
				row[k] = $random(seed) & 32'hFFF;
				act[k] = 1;
				cmd(sdcb_pkg::sdcb_open, k, row[k]);
				cmp();
			end
			b = $random(seed) & 32'h3;
			b2 = (b + 1) % 4;
			rd(b, $random(seed) & 32'hFF);
			chk("latency", 48'(cl), 48'(lat));
			chk("words", 48'h1, 48'(hi));
			apb(1'b1, `SDCB_REG_MASK, 32'hF);
			chk("pslverr", 48'h0, {47'h0, e});
			rd(b, $random(seed) & 32'hFF);
			chk("masked words", 48'h0, 48'(hi));
			apb(1'b1, `SDCB_REG_MASK, 32'h0);
			rd(b, 32'h400 | ($random(seed) & 32'hFF));
			act[b] = 0;
			cmp();
			cmd(sdcb_pkg::sdcb_write, b2, 0);
			cmp();
			cmd(sdcb_pkg::sdcb_close, b2, 0);
			act[b2] = 0;
			cmp();
			cmd(sdcb_pkg::sdcb_close_all, 0, 32'h400);
			act = '{0, 0, 0, 0};
			cmp();
		end
		end_sim();
	end
endmodule
`default_nettype wire
